//--- gdcs_pkg.sv
// Package for the gate drive current sequencer: register map, field
// layouts, reset values, current tables and timing constants.
// Assumes a 32-bit AHB-Lite register bus and a 50 MHz clock.
package gdcs_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CURRENT = 8'h00;
    localparam logic [7:0] ADDR_PDR = 8'h04;
    localparam logic [7:0] ADDR_TIMING = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_MEASURE = 8'h10;
    localparam logic [7:0] ADDR_APPLIED = 8'h14;
    // Current register fields
    localparam int SRC_LSB = 0;
    localparam int SNK_LSB = 4;
    localparam int LOR_BIT = 8;
    localparam int ADV_BIT = 9;
    localparam int MODE_BIT = 10;
    localparam int FWM_LSB = 12;
    localparam int THR_LSB = 16;
    // Gain/init register fields
    localparam int CHI_LSB = 0;
    localparam int DCI_LSB = 8;
    localparam int KPP_LSB = 16;
    localparam int KPS_LSB = 20;
    localparam int PMAX_LSB = 24;
    // Timing register fields, all in clock cycles
    localparam int TDRV_LSB = 0;
    localparam int TPC_LSB = 8;
    localparam int TPD_LSB = 16;
    localparam int TDLY_LSB = 24;
    // Reset values
    localparam logic [31:0] RST_CURRENT = 32'h0000_0088;
    localparam logic [31:0] RST_PDR = 32'hf011_1010;
    localparam logic [31:0] RST_TIMING = 32'h3008_0840;
    localparam logic [31:0] RST_TRF = 32'h0000_0010;
    localparam logic [7:0] ADDR_TRF = 8'h18;
    // Hold current code applied after the drive interval of a rising PWM edge
    localparam logic [3:0] HOLD_CODE = 4'h0;
    localparam logic [7:0] CUR_MAX = 8'hff;
    // Normal range currents in 0.5 mA units
    localparam logic [7:0] NORM_TAB [16] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a,
        8'h0c, 8'h0e, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h3e, 8'h60, 8'h7c};
    // Low range currents in 10 uA units
    localparam logic [7:0] LOW_TAB [16] = '{8'h05, 8'h0b, 8'h11, 8'h17, 8'h1d, 8'h23,
        8'h29, 8'h3c, 8'h48, 8'h55, 8'h64, 8'h78, 8'h8c, 8'ha0, 8'hb4, 8'he6};
    typedef enum logic [2:0] {
        GDCS_IDLE = 3'b000, GDCS_PRE = 3'b001, GDCS_DRIVE = 3'b011,
        GDCS_POST = 3'b010, GDCS_HOLD = 3'b110
    } gdcs_phase_e;
    // Gate current command to the analog stage
    typedef struct packed {
        logic src_en;
        logic snk_en;
        logic low_range;
        logic [7:0] level;
        logic [3:0] code;
    } gdcs_drive_s;
endpackage : gdcs_pkg

//--- gdcs_top.sv
// Gate drive current sequencer: AHB-Lite registers, phase sequencing of
// peak, pre, post and hold currents, freewheel currents from the current register, switch-node timing.
// Assumes switch-node comparator levels and the PWM pin are asynchronous.
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
module gdcs_top
    import gdcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pwm_in,
    input wire logic sn_above_low,
    input wire logic sn_above_high,
    output gdcs_drive_s drive,
    output logic [7:0] fw_chr_level,
    output logic [7:0] fw_dchr_level,
    output logic [1:0] threshold_sel,
    output logic fault_blank
);
    // Registers
    logic [31:0] reg_current;
    logic [31:0] reg_pdr;
    logic [31:0] reg_timing;
    logic [31:0] reg_trf;
    logic [3:0] source_current_code;
    logic [3:0] sink_current_code;
    logic low_range_select;
    logic adv_en;
    logic hb_mode;
    logic [7:0] pre_chr_cur;
    logic [7:0] pre_dchr_cur;
    logic locked;
    logic [7:0] ton_meas;
    logic [7:0] toff_meas;
    logic [7:0] trise_meas;
    logic [7:0] tfall_meas;
    logic [3:0] err_flags;
    // Bus pipeline
    logic wr_pend;
    logic [7:0] wr_addr;
    // Synchronisers
    logic [2:0] pwm_s1;
    logic pwm_s2;
    logic low_s2;
    logic high_s2;
    logic pwm_d;
    // Sequencer
    gdcs_phase_e phase;
    logic rising;
    logic [7:0] tcount;
    logic [7:0] dcount;
    logic low_seen;
    logic high_seen;
    logic [7:0] edge_t;

    // Table lookup of the current level for a code
    function automatic logic [7:0] level_of(input logic [3:0] code, input logic lo);
        level_of = lo ? LOW_TAB[code] : NORM_TAB[code];
    endfunction : level_of

    // Saturating step of a loop current
    function automatic logic [7:0] step_sat(input logic [7:0] cur, input logic [3:0] gain,
                                            input logic up, input logic [7:0] lim);
        logic [8:0] t;
        t = 9'h000;
        if (up) begin
            t = {1'b0, cur} + {5'h00, gain};
            step_sat = (t > {1'b0, lim}) ? lim : t[7:0];
        end else begin
            step_sat = (cur > {4'h0, gain}) ? cur - {4'h0, gain} : 8'h00;
        end
    endfunction : step_sat

    // Delay measured against target: sets up-request when too slow
    function automatic logic too_slow(input logic [7:0] meas, input logic [7:0] tgt);
        too_slow = meas > tgt;
    endfunction : too_slow

    // AHB-Lite slave: zero wait, OKAY always, write data in data phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    ADDR_CURRENT: hrdata <= reg_current;
                    ADDR_PDR: hrdata <= reg_pdr;
                    ADDR_TIMING: hrdata <= reg_timing;
                    ADDR_TRF: hrdata <= reg_trf;
                    ADDR_STATUS: hrdata <= {20'h00000, err_flags, locked, adv_en && hb_mode,
                                            1'b0, 2'b00, phase};
                    ADDR_MEASURE: hrdata <= {trise_meas, tfall_meas, toff_meas, ton_meas};
                    ADDR_APPLIED: hrdata <= {pre_dchr_cur, pre_chr_cur, 7'h00,
                                             low_range_select, sink_current_code,
                                             source_current_code};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Bus answers without wait states
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Configuration registers written by software
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_current <= RST_CURRENT;
            reg_pdr <= RST_PDR;
            reg_timing <= RST_TIMING;
            reg_trf <= RST_TRF;
        end else if (wr_pend) begin
            case (wr_addr)
                ADDR_CURRENT: reg_current <= hwdata;
                ADDR_PDR: reg_pdr <= hwdata;
                ADDR_TIMING: reg_timing <= hwdata;
                ADDR_TRF: reg_trf <= hwdata;
                default: ;
            endcase
        end
    end

    // Two-flop synchronisers for pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwm_s1 <= 3'b000;
            pwm_s2 <= 1'b0;
            low_s2 <= 1'b0;
            high_s2 <= 1'b0;
            pwm_d <= 1'b0;
        end else begin
            pwm_s1 <= {sn_above_high, sn_above_low, pwm_in};
            pwm_s2 <= pwm_s1[0];
            low_s2 <= pwm_s1[1];
            high_s2 <= pwm_s1[2];
            pwm_d <= pwm_s2;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            source_current_code <= RST_CURRENT[SRC_LSB +: 4];
            sink_current_code <= RST_CURRENT[SNK_LSB +: 4];
            low_range_select <= RST_CURRENT[LOR_BIT];
            adv_en <= RST_CURRENT[ADV_BIT];
            hb_mode <= RST_CURRENT[MODE_BIT];
        end else if (pwm_s2 != pwm_d) begin
            source_current_code <= reg_current[SRC_LSB +: 4];
            sink_current_code <= reg_current[SNK_LSB +: 4];
            low_range_select <= reg_current[LOR_BIT];
            adv_en <= reg_current[ADV_BIT];
            hb_mode <= reg_current[MODE_BIT];
        end
    end

    // Phase sequencer driven by PWM edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= GDCS_IDLE;
            rising <= 1'b0;
            tcount <= 8'h00;
        end else if (pwm_s2 != pwm_d) begin
            rising <= pwm_s2;
            tcount <= 8'h00;
            phase <= (reg_current[ADV_BIT] && reg_current[MODE_BIT]) ? GDCS_PRE : GDCS_DRIVE;
        end else begin
            tcount <= (tcount == CUR_MAX) ? tcount : tcount + 8'h01;
            case (phase)
                GDCS_PRE: if (tcount >= (rising ? reg_timing[TPC_LSB +: 8]
                                                 : reg_timing[TPD_LSB +: 8])) begin
                    phase <= GDCS_DRIVE;
                    tcount <= 8'h00;
                end
                GDCS_DRIVE: if (tcount >= reg_timing[TDRV_LSB +: 8]) begin
                    phase <= (adv_en && hb_mode && reg_pdr[KPS_LSB +: 4] != 4'h0)
                             ? GDCS_POST : GDCS_HOLD;
                    tcount <= 8'h00;
                end
                GDCS_POST: if (tcount >= reg_timing[TDLY_LSB +: 8]) begin
                    phase <= GDCS_HOLD;
                end
                GDCS_HOLD: phase <= GDCS_HOLD;
                GDCS_IDLE: phase <= GDCS_IDLE;
                default: phase <= GDCS_IDLE;
            endcase
        end
    end

    // Delay and slew timing from the synchronised PWM edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dcount <= 8'h00;
            low_seen <= 1'b0;
            high_seen <= 1'b0;
            edge_t <= 8'h00;
            ton_meas <= 8'h00;
            toff_meas <= 8'h00;
            trise_meas <= 8'h00;
            tfall_meas <= 8'h00;
        end else if (pwm_s2 != pwm_d) begin
            dcount <= 8'h00;
            low_seen <= 1'b0;
            high_seen <= 1'b0;
        end else begin
            dcount <= (dcount == CUR_MAX) ? dcount : dcount + 8'h01;
            if (rising && !low_seen && low_s2) begin
                low_seen <= 1'b1;
                ton_meas <= dcount;
                edge_t <= dcount;
            end
            if (rising && low_seen && !high_seen && high_s2) begin
                high_seen <= 1'b1;
                trise_meas <= dcount - edge_t;
            end
            if (!rising && !high_seen && !high_s2) begin
                high_seen <= 1'b1;
                toff_meas <= dcount;
                edge_t <= dcount;
            end
            if (!rising && high_seen && !low_seen && !low_s2) begin
                low_seen <= 1'b1;
                tfall_meas <= dcount - edge_t;
            end
        end
    end

    // Comparison of measured times with targets
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_flags <= 4'h0;
        end else begin
            err_flags[0] <= too_slow(ton_meas, reg_timing[TDLY_LSB +: 8]);
            err_flags[1] <= too_slow(toff_meas, reg_timing[TDLY_LSB +: 8]);
            err_flags[2] <= too_slow(trise_meas, reg_trf[7:0]);
            err_flags[3] <= too_slow(tfall_meas, reg_trf[7:0]);
        end
    end

    // Pre-charge loop currents, updated once per measured edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_chr_cur <= RST_PDR[CHI_LSB +: 8];
            pre_dchr_cur <= RST_PDR[DCI_LSB +: 8];
            locked <= 1'b0;
        end else if (!(adv_en && hb_mode)) begin
            pre_chr_cur <= reg_pdr[CHI_LSB +: 8];
            pre_dchr_cur <= reg_pdr[DCI_LSB +: 8];
            locked <= 1'b0;
        end else if (pwm_s2 != pwm_d) begin
            locked <= 1'b1;
            if (locked && !pwm_s2) begin
                pre_chr_cur <= step_sat(pre_chr_cur, reg_pdr[KPP_LSB +: 4],
                    too_slow(ton_meas, reg_timing[TDLY_LSB +: 8]), reg_pdr[PMAX_LSB +: 8]);
            end
            if (locked && pwm_s2) begin
                pre_dchr_cur <= step_sat(pre_dchr_cur, reg_pdr[KPP_LSB +: 4],
                    too_slow(toff_meas, reg_timing[TDLY_LSB +: 8]), reg_pdr[PMAX_LSB +: 8]);
            end
        end
    end

    // Gate current command per phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive <= '0;
            fault_blank <= 1'b0;
        end else begin
            drive.src_en <= (phase != GDCS_IDLE) && rising;
            drive.snk_en <= (phase != GDCS_IDLE) && !rising;
            drive.low_range <= low_range_select;
            fault_blank <= (phase == GDCS_DRIVE) || (phase == GDCS_PRE);
            case (phase)
                GDCS_PRE: begin
                    drive.code <= rising ? source_current_code : sink_current_code;
                    drive.level <= rising ? pre_chr_cur : pre_dchr_cur;
                end
                GDCS_DRIVE: begin
                    drive.code <= rising ? source_current_code : sink_current_code;
                    drive.level <= level_of(rising ? source_current_code : sink_current_code,
                                            low_range_select);
                end
                GDCS_POST: begin
                    drive.code <= rising ? source_current_code : sink_current_code;
                    drive.level <= step_sat(level_of(rising ? source_current_code
                        : sink_current_code, low_range_select),
                        reg_pdr[KPS_LSB +: 4], 1'b1, CUR_MAX);
                end
                GDCS_HOLD: begin
                    drive.code <= rising ? HOLD_CODE : sink_current_code;
                    drive.level <= rising ? level_of(HOLD_CODE, 1'b0) : CUR_MAX;
                end
                default: begin
                    drive.code <= HOLD_CODE;
                    drive.level <= 8'h00;
                end
            endcase
        end
    end

    // Freewheel currents and comparator thresholds
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fw_chr_level <= 8'h00;
            fw_dchr_level <= 8'h00;
            threshold_sel <= 2'b00;
        end else begin
            fw_chr_level <= {4'h0, reg_current[FWM_LSB +: 4]};
            fw_dchr_level <= {4'h0, reg_current[FWM_LSB +: 4]};
            threshold_sel <= reg_current[THR_LSB +: 2];
        end
    end
endmodule : gdcs_top

//--- gdcs_top_sva.sv
// Checker for the gate drive current sequencer top module.
// Assumes binding to gdcs_top; sees only its ports, one clock domain.
`timescale 1ns/100ps
module gdcs_top_chk
    import gdcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic pwm_in,
    input wire gdcs_drive_s drive,
    input wire logic [7:0] fw_chr_level,
    input wire logic [7:0] fw_dchr_level,
    input wire logic [1:0] threshold_sel,
    input wire logic fault_blank
);
    logic [2:0] cur_wr_cnt;
    // Window after a control write in which its fields may move
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_wr_cnt <= 3'h0;
        end else if (hsel && hready && htrans[1] && hwrite && haddr[7:0] == ADDR_CURRENT) begin
            cur_wr_cnt <= 3'h5;
        end else if (cur_wr_cnt != 3'h0) begin
            cur_wr_cnt <= cur_wr_cnt - 3'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_src_on;
        ##[1:7] (drive.src_en && !drive.snk_en);
    endsequence
    sequence s_snk_on;
        ##[1:7] (drive.snk_en && !drive.src_en);
    endsequence
    property p_bus_okay; hreadyout && !hresp; endproperty
    property p_fw_pair; fw_chr_level == fw_dchr_level; endproperty
    property p_fw_cause; $changed(fw_chr_level) |-> cur_wr_cnt != 3'h0; endproperty
    property p_thr_cause; $changed(threshold_sel) |-> cur_wr_cnt != 3'h0; endproperty
    property p_turn_on; $rose(pwm_in) |-> s_src_on; endproperty
    property p_turn_off; $fell(pwm_in) |-> s_snk_on; endproperty
    property p_one_side; !(drive.src_en && drive.snk_en); endproperty
    property p_blank_start; $rose(pwm_in) |-> ##[1:7] fault_blank; endproperty
    property p_blank_drive; fault_blank |-> ##[0:1] (drive.src_en || drive.snk_en); endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus answer not ready and okay");
    a_fw_pair: assert property (p_fw_pair)
        else $error("freewheel charge and discharge levels differ");
    a_fw_cause: assert property (p_fw_cause)
        else $error("freewheel level moved without a control write");
    a_thr_cause: assert property (p_thr_cause)
        else $error("threshold select moved without a control write");
    a_turn_on: assert property (p_turn_on)
        else $error("source drive missing after pwm rise");
    a_turn_off: assert property (p_turn_off)
        else $error("sink drive missing after pwm fall");
    a_one_side: assert property (p_one_side)
        else $error("source and sink enabled together");
    a_blank_start: assert property (p_blank_start)
        else $error("fault blanking missing after pwm rise");
    a_blank_drive: assert property (p_blank_drive)
        else $error("blanking without gate current");
endmodule : gdcs_top_chk

bind gdcs_top gdcs_top_chk u_chk (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .pwm_in(pwm_in), .drive(drive), .fw_chr_level(fw_chr_level),
    .fw_dchr_level(fw_dchr_level), .threshold_sel(threshold_sel), .fault_blank(fault_blank));

//--- gdcs_bridge_model.sv
// Behavioural half-bridge switch node driven by the gate command.
// Assumes one clock; node voltage kept as 0..100 percent of the rail.
`timescale 1ns/100ps
module gdcs_bridge_model
    import gdcs_pkg::*;
(
    input wire logic clk,
    input wire logic slow,
    input wire logic [1:0] threshold_sel,
    input wire gdcs_drive_s drive,
    output logic sn_above_low,
    output logic sn_above_high
);
    int node = 0;
    int step;
    assign step = slow ? 1 : 20;
    // Slew the node toward the rail the gate command favours
    always @(posedge clk) begin
        if (drive.src_en && !drive.snk_en) begin
            node <= (node + step > 100) ? 100 : node + step;
        end else if (drive.snk_en && !drive.src_en) begin
            node <= (node - step < 0) ? 0 : node - step;
        end
    end
    assign sn_above_low = node > 20 + 5 * int'(threshold_sel);
    assign sn_above_high = node > 80 - 5 * int'(threshold_sel);
endmodule : gdcs_bridge_model

//--- tb.sv
// Self-checking bench for the gate drive current sequencer.
// Assumes the bridge model on the far side and the bound checker.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb
    import gdcs_pkg::*;
;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, pwm_in = 0, slow = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, cw;
    logic [1:0] htrans = 0, threshold_sel;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, fault_blank, sn_above_low, sn_above_high;
    logic [7:0] fw_chr_level, fw_dchr_level, tdrv, chi, dci, post_exp = 8'h00;
    gdcs_drive_s drive, fd;
    int err_count = 0, check_count = 0, cyc = 0, len, seed = 32'h27ea56c2;
    logic [7:0] ra [5] = '{ADDR_CURRENT, ADDR_PDR, ADDR_TIMING, ADDR_TRF, 8'h40};
    logic [31:0] rv [5] = '{RST_CURRENT, RST_PDR, RST_TIMING, RST_TRF, 32'h0};
    gdcs_top dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_in(pwm_in),
        .sn_above_low(sn_above_low), .sn_above_high(sn_above_high), .drive(drive),
        .fw_chr_level(fw_chr_level), .fw_dchr_level(fw_dchr_level),
        .threshold_sel(threshold_sel), .fault_blank(fault_blank));
    gdcs_bridge_model u_bridge (.clk(clk), .slow(slow), .threshold_sel(threshold_sel),
        .drive(drive), .sn_above_low(sn_above_low), .sn_above_high(sn_above_high));
    // Clock and cycle count
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // Peak current in 0.5 mA units, or 10 uA units in low range
    function automatic logic [7:0] peak_level(input logic lr, input logic [3:0] c);
        logic [7:0] nt [16] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e,
            8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h3e, 8'h60, 8'h7c};
        logic [7:0] lt [16] = '{8'h05, 8'h0b, 8'h11, 8'h17, 8'h1d, 8'h23, 8'h29, 8'h3c,
            8'h48, 8'h55, 8'h64, 8'h78, 8'h8c, 8'ha0, 8'hb4, 8'he6};
        return lr ? lt[c] : nt[c];
    endfunction : peak_level
    // One single AHB-Lite transfer, address phase then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    // PWM edge, first gate command, optional write while blanked, blank length
    task automatic run_edge(input logic lvl, input logic wr, input logic [31:0] wv,
            output int n, output gdcs_drive_s f);
        int t0;
        logic [31:0] dummy;
        n = 0;
        @(posedge clk) pwm_in <= lvl;
        while (fault_blank !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        t0 = cyc;
        @(negedge clk);
        f = drive;
        if (wr) begin
            bus(ADDR_CURRENT, 1'b1, wv, dummy);
            @(negedge clk);
            // Let a wrongly latched code reach the drive outputs
            repeat (2) @(negedge clk);
            `CHK("held code", f.code, drive.code)
        end
        while (fault_blank === 1'b1 && cyc - t0 < 900) @(negedge clk);
        n = cyc - t0;
    endtask : run_edge
    // Advanced edge: pre level, phase length, then let the node settle
    task automatic adv_edge(input logic lvl, input int exp_len, input logic [7:0] lv,
            input logic chk_lv);
        run_edge(lvl, 1'b0, 32'h0, len, fd);
        if (chk_lv) `CHK("pre level", lv, fd.level)
        `CHK("blank length", exp_len, len)
        // Post phase follows the drive interval when its gain is set
        if (post_exp != 8'h00) `CHK("post level", post_exp, drive.level)
        repeat (120) @(negedge clk);
    endtask : adv_edge
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // Watchdog
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            bus(ra[k], 1'b0, 32'h0, rd);
            `CHK("reset value", rv[k], rd)
        end
        bus(8'h40, 1'b1, 32'hffff_ffff, rd);
        bus(8'h40, 1'b0, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        bus(ADDR_PDR, 1'b1, 32'hff01_2010, rd);
        for (int i = 0; i < 32; i++) begin
            tdrv = 8'(12 + ($random(seed) & 15));
            cw = $random(seed) & 32'h0003_f0ff;
            cw[3:0] = i[3:0];
            cw[8] = i[4];
            bus(ADDR_TIMING, 1'b1, {8'h30, 8'h08, 8'h08, tdrv}, rd);
            bus(ADDR_CURRENT, 1'b1, cw, rd);
            run_edge(1'b1, 1'b1, cw ^ 32'h5, len, fd);
            `CHK("source code", cw[3:0], fd.code)
            `CHK("source level", peak_level(cw[8], cw[3:0]), fd.level)
            `CHK("range", cw[8], fd.low_range)
            `CHK("drive length", int'(tdrv) + 1, len)
            repeat (2) @(negedge clk);
            `CHK("hold code", HOLD_CODE, drive.code)
            `CHK("threshold", cw[17:16], threshold_sel)
            `CHK("freewheel", {4'h0, cw[15:12]}, fw_chr_level)
            run_edge(1'b0, 1'b0, 32'h0, len, fd);
            `CHK("sink code", cw[7:4], fd.code)
            `CHK("sink level", peak_level(cw[8], cw[7:4]), fd.level)
        end
        for (int s = 0; s < 3; s++) begin
            chi = 8'(8 + ($random(seed) & 63));
            dci = 8'(8 + ($random(seed) & 63));
            tdrv = 8'(4 + ($random(seed) & 7));
            slow <= (s == 1);
            post_exp = (s == 0) ? peak_level(1'b0, 4'h8) + 8'h03 : 8'h00;
            bus(ADDR_PDR, 1'b1, {8'hff, (s == 0) ? 4'h3 : 4'h0, 4'h1, dci, chi}, rd);
            bus(ADDR_TIMING, 1'b1, {(s == 1) ? 8'h04 : 8'hc8, tdrv, tdrv + 8'h2, 8'h0a}, rd);
            if (s == 1) begin
                bus(ADDR_CURRENT, 1'b1, 32'h88, rd);
                adv_edge(1'b1, 11, 8'h0, 1'b0);
            end
            bus(ADDR_CURRENT, 1'b1, (s == 2) ? 32'h288 : 32'h688, rd);
            if (s == 0) adv_edge(1'b1, int'(tdrv) + 14, chi, 1'b1);
            if (s != 2) adv_edge(1'b0, int'(tdrv) + 12, dci, s == 1);
            if (s != 0) adv_edge(1'(s == 1), (s == 2) ? 11 : int'(tdrv) + 14, 8'h0, 1'b0);
            bus(ADDR_STATUS, 1'b0, 32'h0, rd);
            `CHK("adv active", 1'(s != 2), rd[6])
            if (s != 2) `CHK("timing errors", {4{1'(s == 1)}}, rd[11:8])
            if (s == 2) adv_edge(1'b1, 11, 8'h0, 1'b0);
        end
        complete_run();
    end
endmodule : tb
